// >>> include/apc_pkg.sv
// Types and rate decoding of the playback core
`include "apc_regs.svh"
package apc_pkg;

	typedef enum logic [3:0] {
		ST_BOOT, ST_IDLE, ST_PD, ST_IDX_HI, ST_IDX_LO, ST_SCR_OP,
		ST_SCR_A1, ST_SCR_A2, ST_CLIP_HDR, ST_LEN_HI, ST_LEN_LO, ST_PLAY
	} apc_state_t;

	typedef struct packed {
		logic       sel_n;
		logic [5:0] gp;
	} apc_pins_t;

	typedef struct packed {
		apc_pins_t        s1;
		apc_pins_t        s2;
		apc_pins_t        pv;
		logic [7:0]       shin;
		logic [7:0]       shout;
		logic [2:0]       bitc;
		logic [1:0]       bidx;
		logic [7:0]       scmd;
		logic [7:0]       sarg;
		logic             miso;
		logic [15:0][7:0] cfg;
		apc_state_t       st;
		logic             kind;
		logic             in_scr;
		logic [11:0]      ptr;
		logic [11:0]      pc;
		logic [7:0]       hi;
		logic [7:0]       op;
		logic [7:0]       hdr;
		logic [15:0]      len;
		logic [10:0]      tick;
		logic [4:0]       half;
		logic             pd;
		logic             err;
		logic             osc;
		logic [11:0]      faddr;
		logic             er_act;
		logic [9:0]       er_cnt;
		logic             ack;
		logic [31:0]      rdata;
		logic [7:0]       smp;
		logic             stb;
		logic [5:0]       go;
		logic [5:0]       goe;
		logic [5:0]       gpu;
		logic [5:0]       gpd;
	} apc_core_t;

	// Half periods of the maximum rate per sample, zero for code 7
	function automatic logic [4:0] apc_ratio2(input logic [2:0] rate);
		case (rate)
			3'h0: apc_ratio2 = `APC_HT_R0;
			3'h1: apc_ratio2 = `APC_HT_R1;
			3'h2: apc_ratio2 = `APC_HT_R2;
			3'h3: apc_ratio2 = `APC_HT_R3;
			3'h4: apc_ratio2 = `APC_HT_R4;
			3'h5: apc_ratio2 = `APC_HT_R5;
			3'h6: apc_ratio2 = `APC_HT_R6;
			default: apc_ratio2 = 5'h00;
		endcase
	endfunction : apc_ratio2

endpackage : apc_pkg

// >>> include/apc_regs.svh
// Offsets, table layout, command codes and timing counts of the playback core
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

// Avalon byte offsets
`define APC_OFS_CTRL      8'h00
`define APC_OFS_STATUS    8'h04
`define APC_OFS_FADDR     8'h08
`define APC_OFS_FDATA     8'h0C
`define APC_OFS_FERASE    8'h10
`define APC_CFG_WIN       2'h1
// CTRL and STATUS bit positions
`define APC_CTRL_PLAY     0
`define APC_CTRL_EXEC     1
`define APC_CTRL_PDN      2
`define APC_CTRL_PUP      3
`define APC_STAT_ERR      3
// Configuration register indices
`define APC_CFG_OE        4'h0
`define APC_CFG_OUT       4'h1
`define APC_CFG_PU        4'h2
`define APC_CFG_PD        4'h3
`define APC_CFG_AF        4'h4
`define APC_CFG_FALL      4'h5
`define APC_CFG_RISE      4'h6
`define APC_CFG_JUMP0     4'h7
`define APC_CFG_KEPT_LAST 4'hC
`define APC_CFG_VOL       4'hD
`define APC_VOLATILE_RST  8'h00
// Storage: 4 Kbyte array, 1 Kbyte erase sectors
`define APC_MEM_AW        12
`define APC_MEM_BYTES     4096
`define APC_ERASED        8'hFF
`define APC_IDX_BASE      12'h010
`define APC_IDX_NONE      16'hFFFF
`define APC_IDX_POI       8'h00
`define APC_IDX_PU        8'h01
// Script opcodes; anything else finishes the script
`define APC_OP_WRCFG      8'h01
`define APC_OP_PLAY       8'h02
`define APC_OP_PDN        8'h03
// Serial command codes
`define APC_SPI_PLAY      8'hA0
`define APC_SPI_EXEC      8'hA1
`define APC_SPI_WRCFG     8'hA2
`define APC_SPI_PDN       8'hA3
`define APC_SPI_PUP       8'hA4
// Rate codes, in half periods of the maximum rate
`define APC_RATE_BAD      3'h7
`define APC_HT_R0         5'h10
`define APC_HT_R1         5'h0C
`define APC_HT_R2         5'h0A
`define APC_HT_R3         5'h08
`define APC_HT_R4         5'h05
`define APC_HT_R5         5'h04
`define APC_HT_R6         5'h02
// Timing
`define APC_CLK_HZ        125000000
`define APC_FSMAX_HZ      32000
`define APC_TICK_CYC      (`APC_CLK_HZ / (2 * `APC_FSMAX_HZ))

`endif

// >>> rtl/apc_core.sv
// Playback control core: pin sharing, triggers, scripts, clips, storage
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "apc_regs.svh"

module apc_core (
	input  logic        MCLK_I,
	input  logic        RST_I,
	input  logic [7:0]  AVS_ADDRESS_I,
	input  logic        AVS_READ_I,
	input  logic        AVS_WRITE_I,
	input  logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic        AVS_WAITREQUEST_O,
	input  logic        SELECT_N_I,
	input  logic [5:0]  GPIO_I,
	output logic [5:0]  GPIO_O,
	output logic [5:0]  GPIO_OE_O,
	output logic [5:0]  GPIO_PU_O,
	output logic [5:0]  GPIO_PD_O,
	output logic [7:0]  SAMPLE_O,
	output logic        SAMPLE_STB_O,
	output logic [4:0]  CLIP_COMP_O,
	output logic [2:0]  CLIP_RATE_O,
	output logic        PLAYING_O,
	output logic        PWR_DN_O
);

	apc_pkg::apc_core_t q;
	apc_pkg::apc_core_t d;
	// Table at 0x010, then scripts, clips, user sectors, all by index
	logic [7:0]  mem [0:`APC_MEM_BYTES-1] = '{default: `APC_ERASED};
	logic [11:0] rd_addr;
	logic [7:0]  mrd;
	logic [7:0]  fl_rd;
	logic        spi_on;
	logic        clock_shared_input;
	logic        sck_r;
	logic        sck_f;
	logic        byte_done;
	logic [7:0]  sbyte;
	logic [7:0]  status;
	logic        busy;
	logic        playing;
	logic        req;
	logic        stall;
	logic        wr_acc;
	logic        prog;
	logic        tick_evt;
	logic [5:0]  trig_vec;
	logic [2:0]  trig_idx;
	logic [7:0]  jump;
	logic        spi_play;
	logic        spi_exec;
	logic        spi_pdn;
	logic        spi_pup;
	logic        bus_play;
	logic        bus_exec;
	logic        bus_pdn;
	logic        bus_pup;
	logic [15:0] ent;

	////////////////////////////////////////////////////////////////////////
	// Engine helpers

	// Start an index lookup for a script or clip
	function automatic apc_pkg::apc_core_t lookup(
		input apc_pkg::apc_core_t s, input logic [7:0] idx,
		input logic scr_kind, input logic scr);
		s.ptr    = `APC_IDX_BASE + {3'h0, idx, 1'b0};
		s.kind   = scr_kind;
		s.in_scr = scr;
		s.st     = apc_pkg::ST_IDX_HI;
		return s;
	endfunction : lookup

	// End of a clip or script: back to the calling script or idle
	function automatic apc_pkg::apc_core_t finish(
		input apc_pkg::apc_core_t s);
		if (s.in_scr && !s.kind) begin
			s.st = apc_pkg::ST_SCR_OP;
		end else begin
			s.st     = apc_pkg::ST_IDLE;
			s.in_scr = 1'b0;
		end
		return s;
	endfunction : finish

	// Power-down: only pin config and jump registers are kept
	function automatic apc_pkg::apc_core_t enter_pd(
		input apc_pkg::apc_core_t s);
		s.pd     = 1'b1;
		s.st     = apc_pkg::ST_PD;
		s.in_scr = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (4'(i) > `APC_CFG_KEPT_LAST) begin
				s.cfg[i] = `APC_VOLATILE_RST;
			end
		end
		return s;
	endfunction : enter_pd

	////////////////////////////////////////////////////////////////////////
	// Shared decode

	// Serial pins claimed while selected; clock edges from synced pin
	assign spi_on             = ~q.s2.sel_n;
	assign clock_shared_input = q.s2.gp[1];
	assign sck_r     = spi_on & clock_shared_input & ~q.pv.gp[1];
	assign sck_f     = spi_on & ~clock_shared_input & q.pv.gp[1];
	assign byte_done = sck_r & (q.bitc == 3'h7);
	assign sbyte     = {q.shin[6:0], q.s2.gp[0]};
	assign playing   = (q.st == apc_pkg::ST_PLAY);
	assign busy      = (q.st != apc_pkg::ST_IDLE) && (q.st != apc_pkg::ST_PD);
	assign status    = {4'h0, q.err, q.pd, playing, busy};
	// Memory ports
	assign rd_addr = (q.st inside {apc_pkg::ST_SCR_OP, apc_pkg::ST_SCR_A1,
		apc_pkg::ST_SCR_A2}) ? q.pc : q.ptr;
	assign mrd     = mem[rd_addr];
	assign fl_rd   = mem[q.faddr];
	// Avalon handshake: answer on the second edge of each request, later for flash registers during an erase
	assign req     = AVS_READ_I | AVS_WRITE_I;
	assign stall   = q.er_act && (AVS_ADDRESS_I inside {`APC_OFS_FADDR,
		`APC_OFS_FDATA, `APC_OFS_FERASE});
	assign AVS_WAITREQUEST_O = req & ~q.ack;
	assign wr_acc  = AVS_WRITE_I & q.ack;
	assign prog    = wr_acc && (AVS_ADDRESS_I == `APC_OFS_FDATA);
	assign bus_play = wr_acc && (AVS_ADDRESS_I == `APC_OFS_CTRL)
		&& AVS_WRITEDATA_I[`APC_CTRL_PLAY];
	assign bus_exec = wr_acc && (AVS_ADDRESS_I == `APC_OFS_CTRL)
		&& AVS_WRITEDATA_I[`APC_CTRL_EXEC];
	assign bus_pdn  = wr_acc && (AVS_ADDRESS_I == `APC_OFS_CTRL)
		&& AVS_WRITEDATA_I[`APC_CTRL_PDN];
	assign bus_pup  = wr_acc && (AVS_ADDRESS_I == `APC_OFS_CTRL)
		&& AVS_WRITEDATA_I[`APC_CTRL_PUP];
	assign tick_evt = (q.tick == 11'(`APC_TICK_CYC - 1));
	assign ent      = {q.hi, mrd};

	// Pin edge triggers, lowest pin first, skipped on claimed pins
	always_comb begin
		trig_vec = 6'h00;
		trig_idx = 3'h0;
		for (int i = 0; i < 6; i++) begin
			trig_vec[i] = ~(q.cfg[`APC_CFG_AF][i] | (spi_on & (i < 3)))
				& ((q.s2.gp[i] & ~q.pv.gp[i] & q.cfg[`APC_CFG_RISE][i])
				| (~q.s2.gp[i] & q.pv.gp[i] & q.cfg[`APC_CFG_FALL][i]));
		end
		for (int i = 5; i >= 0; i--) begin
			if (trig_vec[i]) begin
				trig_idx = 3'(i);
			end
		end
		jump = q.cfg[`APC_CFG_JUMP0 + {1'b0, trig_idx}];
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Sync, serial slave, bus registers, engine, pin drive
	always_comb begin
		d = q;
		d.stb = 1'b0;
		spi_play = 1'b0;
		spi_exec = 1'b0;
		spi_pdn  = 1'b0;
		spi_pup  = 1'b0;
		d.s1 = apc_pkg::apc_pins_t'({SELECT_N_I, GPIO_I});
		d.s2 = q.s1;
		d.pv = q.s2;
		d.tick = tick_evt ? 11'h000 : q.tick + 11'h001;
		if (tick_evt) begin
			d.osc = ~q.osc;
		end
		// Serial shifter, mode 3, MSB first
		if (!spi_on) begin
			d.bitc = 3'h0;
			d.bidx = 2'h0;
		end else begin
			if (sck_r) begin
				d.shin = sbyte;
				d.bitc = q.bitc + 3'h1;
			end
			if (sck_f && q.bitc == 3'h0) begin
				d.miso  = status[7];
				d.shout = {status[6:0], 1'b0};
			end else if (sck_f) begin
				d.miso  = q.shout[7];
				d.shout = {q.shout[6:0], 1'b0};
			end
		end
		// Serial command assembly
		if (byte_done && q.bidx == 2'h0) begin
			d.scmd  = sbyte;
			spi_pdn = (sbyte == `APC_SPI_PDN);
			spi_pup = (sbyte == `APC_SPI_PUP);
			d.bidx  = (sbyte inside {`APC_SPI_PLAY, `APC_SPI_EXEC,
				`APC_SPI_WRCFG}) ? 2'h1 : 2'h0;
		end else if (byte_done && q.bidx == 2'h1) begin
			d.sarg   = sbyte;
			spi_play = (q.scmd == `APC_SPI_PLAY);
			spi_exec = (q.scmd == `APC_SPI_EXEC);
			d.bidx   = (q.scmd == `APC_SPI_WRCFG) ? 2'h2 : 2'h0;
		end else if (byte_done) begin
			d.cfg[q.sarg[3:0]] = sbyte;
			d.bidx = 2'h0;
		end
		// Bus read data, captured on every request cycle until the answer
		d.ack = req & ~q.ack & ~stall;
		if (req && !q.ack) begin
			if (AVS_ADDRESS_I[7:6] == `APC_CFG_WIN) begin
				d.rdata = {24'h000000, q.cfg[AVS_ADDRESS_I[5:2]]};
			end else begin
				case (AVS_ADDRESS_I)
					`APC_OFS_STATUS: d.rdata = {24'h000000, status};
					`APC_OFS_FADDR:  d.rdata = {20'h00000, q.faddr};
					`APC_OFS_FDATA:  d.rdata = {24'h000000, fl_rd};
					default:         d.rdata = 32'h00000000;
				endcase
			end
		end
		// Sector erase sweep, one byte per cycle
		if (q.er_act) begin
			d.er_cnt = q.er_cnt + 10'h001;
			d.er_act = ~(&q.er_cnt);
		end
		// Bus register writes
		if (wr_acc) begin
			if (AVS_ADDRESS_I[7:6] == `APC_CFG_WIN) begin
				d.cfg[AVS_ADDRESS_I[5:2]] = AVS_WRITEDATA_I[7:0];
			end else if (AVS_ADDRESS_I == `APC_OFS_STATUS
				&& AVS_WRITEDATA_I[`APC_STAT_ERR]) begin
				d.err = 1'b0;
			end else if (AVS_ADDRESS_I == `APC_OFS_FADDR) begin
				d.faddr = AVS_WRITEDATA_I[11:0];
			end else if (AVS_ADDRESS_I == `APC_OFS_FERASE) begin
				d.er_act = 1'b1;
				d.er_cnt = 10'h000;
			end
		end
		// Commands and triggers take over from whatever runs
		if (q.st == apc_pkg::ST_BOOT) begin
			d = lookup(d, `APC_IDX_POI, 1'b1, 1'b1);
		end else if (q.pd) begin
			if (spi_pup || bus_pup) begin
				d.pd = 1'b0;
				d = lookup(d, `APC_IDX_PU, 1'b1, 1'b1);
			end else if (|trig_vec) begin
				d.pd = 1'b0;
				d = lookup(d, jump, 1'b1, 1'b1);
			end
		end else if (spi_pdn || bus_pdn) begin
			d = enter_pd(d);
		end else if (spi_pup || bus_pup) begin
			d = lookup(d, `APC_IDX_PU, 1'b1, 1'b1);
		end else if (spi_play) begin
			d = lookup(d, sbyte, 1'b0, 1'b0);
		end else if (bus_play || bus_exec) begin
			d = lookup(d, AVS_WRITEDATA_I[15:8], bus_exec, bus_exec);
		end else if (spi_exec) begin
			d = lookup(d, sbyte, 1'b1, 1'b1);
		end else if (|trig_vec) begin
			d = lookup(d, jump, 1'b1, 1'b1);
		end else begin
			unique case (q.st)
				apc_pkg::ST_BOOT, apc_pkg::ST_IDLE, apc_pkg::ST_PD: begin
				end
				apc_pkg::ST_IDX_HI: begin
					d.hi  = mrd;
					d.ptr = q.ptr + 12'h001;
					d.st  = apc_pkg::ST_IDX_LO;
				end
				apc_pkg::ST_IDX_LO: begin
					if (ent == `APC_IDX_NONE) begin
						d = finish(d);
					end else if (q.kind) begin
						d.pc = ent[11:0];
						d.st = apc_pkg::ST_SCR_OP;
					end else begin
						d.ptr = ent[11:0];
						d.st  = apc_pkg::ST_CLIP_HDR;
					end
				end
				apc_pkg::ST_SCR_OP: begin
					d.op = mrd;
					d.pc = q.pc + 12'h001;
					if (mrd == `APC_OP_WRCFG || mrd == `APC_OP_PLAY) begin
						d.st = apc_pkg::ST_SCR_A1;
					end else if (mrd == `APC_OP_PDN) begin
						d = enter_pd(d);
					end else begin
						d.st     = apc_pkg::ST_IDLE;
						d.in_scr = 1'b0;
					end
				end
				apc_pkg::ST_SCR_A1: begin
					d.hi = mrd;
					d.pc = q.pc + 12'h001;
					if (q.op == `APC_OP_PLAY) begin
						d = lookup(d, mrd, 1'b0, 1'b1);
					end else begin
						d.st = apc_pkg::ST_SCR_A2;
					end
				end
				apc_pkg::ST_SCR_A2: begin
					d.cfg[q.hi[3:0]] = mrd;
					d.pc = q.pc + 12'h001;
					d.st = apc_pkg::ST_SCR_OP;
				end
				apc_pkg::ST_CLIP_HDR: begin
					d.hdr = mrd;
					d.ptr = q.ptr + 12'h001;
					if (mrd[2:0] == `APC_RATE_BAD) begin
						d.err = 1'b1;
						d = finish(d);
					end else begin
						d.st = apc_pkg::ST_LEN_HI;
					end
				end
				apc_pkg::ST_LEN_HI: begin
					d.len[15:8] = mrd;
					d.ptr = q.ptr + 12'h001;
					d.st  = apc_pkg::ST_LEN_LO;
				end
				apc_pkg::ST_LEN_LO: begin
					d.len[7:0] = mrd;
					d.ptr  = q.ptr + 12'h001;
					d.half = 5'h00;
					d.st   = apc_pkg::ST_PLAY;
				end
				apc_pkg::ST_PLAY: begin
					if (q.len == 16'h0000) begin
						d = finish(d);
					end else if (tick_evt && q.half + 5'h01
						== apc_pkg::apc_ratio2(q.hdr[2:0])) begin
						d.half = 5'h00;
						d.smp  = mrd;
						d.stb  = 1'b1;
						d.ptr  = q.ptr + 12'h001;
						d.len  = q.len - 16'h0001;
					end else if (tick_evt) begin
						d.half = q.half + 5'h01;
					end
				end
			endcase
		end
		// Pin drive: general config, then alternates and serial claim
		d.gpu = q.cfg[`APC_CFG_PU][5:0];
		d.gpd = q.cfg[`APC_CFG_PD][5:0];
		d.go  = q.cfg[`APC_CFG_OUT][5:0];
		d.goe = q.cfg[`APC_CFG_OE][5:0] & ~q.cfg[`APC_CFG_AF][5:0];
		d.goe[0] = d.goe[0] & ~spi_on;
		d.goe[1] = 1'b0;
		d.go[1]  = 1'b0;
		if (spi_on) begin
			d.goe[2] = 1'b1;
			d.go[2]  = d.miso;
		end
		if (q.cfg[`APC_CFG_AF][3]) begin
			d.go[3]  = 1'b0;
			d.goe[3] = d.err;
		end
		if (q.cfg[`APC_CFG_AF][4]) begin
			d.go[4]  = ~busy;
			d.goe[4] = 1'b1;
		end
		if (q.cfg[`APC_CFG_AF][5]) begin
			d.go[5]  = q.osc;
			d.goe[5] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			q          <= '0;
			q.s1.sel_n <= 1'b1;
			q.s2.sel_n <= 1'b1;
			q.pv.sel_n <= 1'b1;
			q.s1.gp[1] <= 1'b1; // Clock-shared pin idles high
			q.s2.gp[1] <= 1'b1;
			q.pv.gp[1] <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Storage writes: erase to FF, program only clears bits
	always_ff @(posedge MCLK_I) begin
		if (q.er_act) begin
			mem[{q.faddr[11:10], q.er_cnt}] <= `APC_ERASED;
		end else if (prog) begin
			mem[q.faddr] <= fl_rd & AVS_WRITEDATA_I[7:0];
		end
	end

	// Outputs
	assign AVS_READDATA_O = q.rdata;
	assign GPIO_O         = q.go;
	assign GPIO_OE_O      = q.goe;
	assign GPIO_PU_O      = q.gpu;
	assign GPIO_PD_O      = q.gpd;
	assign SAMPLE_O       = q.smp;
	assign SAMPLE_STB_O   = q.stb;
	assign CLIP_COMP_O    = q.hdr[7:3];
	assign CLIP_RATE_O    = q.hdr[2:0];
	assign PLAYING_O      = playing;
	assign PWR_DN_O       = q.pd;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [15:0] gap_q;
	logic        seen_q;
	logic [10:0] er_len_q;

	// Sample spacing and erase length helpers
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			gap_q    <= 16'h0000;
			seen_q   <= 1'b0;
			er_len_q <= 11'h000;
		end else begin
			gap_q    <= q.stb ? 16'h0001 : gap_q + 16'h0001;
			seen_q   <= playing & (seen_q | q.stb);
			er_len_q <= q.er_act ? er_len_q + 11'h001 : 11'h000;
		end
	end

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	sequence s_req_first;
		req && !q.ack && !stall;
	endsequence
	sequence s_boot;
		q.st == apc_pkg::ST_BOOT && !RST_I;
	endsequence

	chk_bus_answer: assert property (s_req_first |=> !AVS_WAITREQUEST_O)
		else $error("bus request not answered on second edge");
	chk_miso_drive: assert property (!q.s2.sel_n |=> GPIO_OE_O[2])
		else $error("data out not driven while selected");
	chk_miso_float: assert property (
		(q.s2.sel_n && q.cfg[`APC_CFG_AF][2]) |=> !GPIO_OE_O[2])
		else $error("data out driven while deselected");
	chk_sclk_input: assert property ($rose(q.cfg[`APC_CFG_OE][1])
		|=> !GPIO_OE_O[1] [*2])
		else $error("clock-shared pin driven");
	chk_rate_reject: assert property (
		(q.st == apc_pkg::ST_CLIP_HDR && mrd[2:0] == `APC_RATE_BAD
		&& !d.pd && d.st != apc_pkg::ST_IDX_HI)
		|=> q.err && q.st != apc_pkg::ST_LEN_HI ##1 !playing)
		else $error("clip with rate code 7 started");
	chk_sample_gap: assert property ((SAMPLE_STB_O && seen_q)
		|-> gap_q == 16'(apc_pkg::apc_ratio2(CLIP_RATE_O) * `APC_TICK_CYC))
		else $error("sample spacing does not match rate code");
	chk_prog_and: assert property (prog |=>
		fl_rd == ($past(fl_rd) & $past(AVS_WRITEDATA_I[7:0])))
		else $error("programming set a bit");
	chk_erase_span: assert property ($fell(q.er_act)
		|-> er_len_q == 11'h400 && fl_rd == `APC_ERASED)
		else $error("erase did not sweep one sector");
	chk_pd_retain: assert property ($rose(q.pd) |->
		q.cfg[`APC_CFG_VOL] == `APC_VOLATILE_RST
		&& q.cfg[`APC_CFG_JUMP0] == $past(q.cfg[`APC_CFG_JUMP0])
		&& q.cfg[`APC_CFG_OE] == $past(q.cfg[`APC_CFG_OE]))
		else $error("power-down config handling wrong");
	chk_boot_poi: assert property (s_boot |=>
		q.st == apc_pkg::ST_IDX_HI && q.kind && q.ptr == `APC_IDX_BASE)
		else $error("power-on script not started");

endmodule : apc_core

// >>> tb/apc_spi_host.sv
// Serial host model: select, idle-high clock, data in, status capture
`timescale 1ns/10ps

module apc_spi_host (
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sel_n_o,
	output logic      sclk_o,
	output logic      mosi_o
);
	logic [7:0] rx_q;

	// Bus idle: deselected, clock high
	initial begin
		sel_n_o = 1'b1;
		sclk_o  = 1'b1;
		mosi_o  = 1'b1;
		rx_q    = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Half of the 64 ns link period
	task automatic half;
		repeat (4) @(posedge clk_i);
	endtask : half

	// Select change, then settle time
	task automatic sel(input logic v);
		sel_n_o <= v;
		half();
		half();
	endtask : sel

	// One byte, MSB first, sampled on rising clock
	task automatic xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o <= 1'b0;
			mosi_o <= tx[i];
			half();
			sclk_o <= 1'b1;
			rx_q   <= {rx_q[6:0], miso_i};
			half();
		end
	endtask : xfer
endmodule : apc_spi_host

// >>> tb/test_apc_core.sv
// Self-checking bench of the playback core
`timescale 1ns/10ps
`include "apc_regs.svh"

module test_apc_core;
	logic        clk  = 1'b0;
	logic        rst  = 1'b1;
	logic [7:0]  adr  = 8'h00;
	logic        ren  = 1'b0;
	logic        wen  = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic        pin5 = 1'b0;
	logic [31:0] rdat;
	logic [5:0]  gpi;
	logic [5:0]  gpo;
	logic [5:0]  gpoe;
	logic [5:0]  gpu;
	logic [5:0]  gpd;
	logic        sel_n;
	logic        sclk;
	logic        mosi;
	logic        wreq;
	logic [7:0]  smp;
	logic        stb;
	logic [4:0]  comp;
	logic [2:0]  rate;
	logic        playing;
	logic        pdn;
	logic [31:0] q;
	int          num_errors = 0;
	int          n_checks   = 0;
	int          n;
	// Index entries 5..7, clips at 0x400 and 0x408, script at 0x800
	localparam logic [19:0] IMG [16] = '{
		20'h01A04, 20'h01B00, 20'h01C04, 20'h01D08, 20'h01E08, 20'h01F00,
		20'h4001E, 20'h40100, 20'h40202, 20'h40311, 20'h40422,
		20'h40807, 20'h40900, 20'h40A01, 20'h80002, 20'h80105};

	// 125 MHz clock
	always #4 clk = ~clk;

	// Data out pin floats to inverse when released
	assign gpi = {pin5, 2'b11, gpoe[2] ? gpo[2] : ~gpo[2], sclk, mosi};

	////////////////////////////////////////////////////////////////////////
	apc_core dut (
		.MCLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(ren),
		.AVS_WRITE_I(wen), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wreq), .SELECT_N_I(sel_n), .GPIO_I(gpi),
		.GPIO_O(gpo), .GPIO_OE_O(gpoe), .GPIO_PU_O(gpu), .GPIO_PD_O(gpd),
		.SAMPLE_O(smp), .SAMPLE_STB_O(stb), .CLIP_COMP_O(comp),
		.CLIP_RATE_O(rate), .PLAYING_O(playing), .PWR_DN_O(pdn));

	apc_spi_host host (
		.clk_i(clk), .miso_i(gpi[2]), .sel_n_o(sel_n), .sclk_o(sclk),
		.mosi_o(mosi));

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	// Value compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int c;
		c = 0;
		adr  <= a;
		wdat <= d;
		wen  <= w;
		ren  <= ~w;
		do begin
			@(posedge clk);
			c++;
			if (c > 2000) begin
				num_errors++;
				print_verdict();
			end
		end while (wreq !== 1'b0);
		r = rdat;
		wen <= 1'b0;
		ren <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rd

	// Bounded wait for strobe (0) or playing (1), counts cycles
	task automatic wait_sig(input int which, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while ((which == 0 ? stb : playing) !== 1'b1 && c < 20000);
		if (c >= 20000) begin
			num_errors++;
			print_verdict();
		end
		@(posedge clk);
	endtask : wait_sig

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(32'(pdn), 32'h0);
		rd(8'hFC, 32'h0);
		wr(`APC_OFS_FADDR, 32'h0);
		wr(`APC_OFS_FERASE, 32'h1);
		rd(`APC_OFS_FDATA, 32'hFF);
		wr(`APC_OFS_FDATA, 32'h5A);
		wr(`APC_OFS_FDATA, 32'hF0);
		rd(`APC_OFS_FDATA, 32'h50);
		wr(`APC_OFS_FADDR, 32'h1);
		rd(`APC_OFS_FDATA, 32'hFF);
		foreach (IMG[i]) begin
			wr(`APC_OFS_FADDR, 32'(IMG[i][19:8]));
			wr(`APC_OFS_FDATA, 32'(IMG[i][7:0]));
		end
		// Clip 5: rate 6, two samples, exact spacing
		wr(`APC_OFS_CTRL, 32'h0501);
		wait_sig(0, n);
		chk(32'(smp), 32'h11);
		chk(32'(rate), 32'h6);
		chk(32'(comp), 32'h3);
		wait_sig(0, n);
		chk(32'(n), 32'(2 * `APC_TICK_CYC));
		chk(32'(smp), 32'h22);
		// Clip 6 carries code 7 and is refused
		wr(`APC_OFS_CTRL, 32'h0601);
		n = 0;
		do begin
			bus(1'b0, `APC_OFS_STATUS, 32'h0, q);
			n++;
		end while (q[3] !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			print_verdict();
		end
		chk(32'(q[3:1]), 32'h4);
		// Serial config write with status byte
		host.sel(1'b0);
		chk(32'(gpoe[2]), 32'h1);
		host.xfer(`APC_SPI_WRCFG);
		chk(32'(host.rx_q), 32'h08);
		host.xfer(8'h0D);
		host.xfer(8'h5A);
		// Serial play of clip 5 while still selected
		host.xfer(`APC_SPI_PLAY);
		host.xfer(8'h05);
		wait_sig(0, n);
		chk(32'(smp), 32'h11);
		wait_sig(0, n);
		chk(32'(smp), 32'h22);
		host.sel(1'b1);
		chk(32'(gpoe[2]), 32'h0);
		rd(8'h74, 32'h5A);
		// Pin config, alternates and pin-5 trigger
		wr(8'h50, 32'h14);
		wr(8'h48, 32'h05);
		wr(8'h4C, 32'h0A);
		wr(8'h40, 32'h3E);
		@(posedge clk);
		chk(32'(gpoe), 32'h38);
		chk(32'(gpu), 32'h05);
		chk(32'(gpd), 32'h0A);
		chk(32'(gpo[4]), 32'h1);
		wr(8'h70, 32'h07);
		wr(8'h58, 32'h20);
		pin5 <= 1'b1;
		wait_sig(1, n);
		chk(32'(playing), 32'h1);
		// Power-down keeps pin and jump config only
		wr(`APC_OFS_CTRL, 32'h4);
		chk(32'(pdn), 32'h1);
		rd(8'h74, 32'h0);
		rd(8'h70, 32'h7);
		rd(8'h40, 32'h3E);
		wr(`APC_OFS_CTRL, 32'h8);
		chk(32'(pdn), 32'h0);
		// Serial power-down and power-up
		host.sel(1'b0);
		host.xfer(`APC_SPI_PDN);
		chk(32'(pdn), 32'h1);
		host.xfer(`APC_SPI_PUP);
		chk(32'(pdn), 32'h0);
		host.sel(1'b1);
		print_verdict();
	end
endmodule : test_apc_core
